// >>> frcct_cpu_model.sv
// CPU side of the 8-bit peripheral bus plus the external count clock source
module frcct_cpu_model
  import frcct_pkg::*;
(
  input  wire logic                    core_clk,
  input  wire logic [frcct_pkg::DATA_W-1:0] bus_rdata_r,
  output frcct_pkg::frcct_bus_req_t    bus_req,
  output logic                         ext_count_clock
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    bus_req = '0;
    ext_count_clock = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    #1 d = bus_rdata_r;
  endtask
  // Upper byte always goes first so the byte latch pairs correctly
  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    wr(a, v[15:8]);
    wr(a + 4'h1, v[7:0]);
  endtask
  task automatic rd16(input logic [3:0] a, output logic [15:0] v);
    logic [7:0] h, l;
    rd(a, h);
    rd(a + 4'h1, l);
    v = {h, l};
  endtask
  // Each level is held three system clocks, above the minimum pulse width
  task automatic ext_pulse();
    @(posedge core_clk) ext_count_clock <= 1'b1;
    repeat (3) @(posedge core_clk);
    ext_count_clock <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
endmodule // frcct_cpu_model

// >>> frcct_pkg.sv
// Constants and types shared by the free-running capture/compare timer
package frcct_pkg;
  localparam int          DATA_W        = 8;
  localparam int          CNT_W         = 16;
  localparam int          ADDR_W        = 4;
  localparam int          NUM_CAP       = 4;
  localparam int          PRESC_W       = 5;
  // Register select codes on the peripheral bus
  localparam logic [3:0]  ADDR_IRQ_EN   = 4'h0;
  localparam logic [3:0]  ADDR_FLAGS    = 4'h1;
  localparam logic [3:0]  ADDR_FRC_HI   = 4'h2;
  localparam logic [3:0]  ADDR_FRC_LO   = 4'h3;
  localparam logic [3:0]  ADDR_CMP_HI   = 4'h4;
  localparam logic [3:0]  ADDR_CMP_LO   = 4'h5;
  localparam logic [3:0]  ADDR_CTRL     = 4'h6;
  localparam logic [3:0]  ADDR_OUT_CTRL = 4'h7;
  localparam logic [3:0]  ADDR_CAP_BASE = 4'h8;
  // Reset values
  localparam logic [7:0]  CTRL_RST      = 8'h00;
  localparam logic [7:0]  OUT_CTRL_RST  = 8'hE0;
  localparam logic [7:0]  OUT_CTRL_FIX  = 8'hE0;
  localparam logic [7:0]  FLAGS_RST     = 8'h00;
  localparam logic [7:0]  IRQ_EN_RST    = 8'h00;
  localparam logic [15:0] CNT_RST       = 16'h0000;
  localparam logic [15:0] CNT_MAX       = 16'hFFFF;
  // Timer control fields
  localparam int          CTRL_EDGE_A   = 7;
  localparam int          CTRL_BUF_A    = 3;
  localparam int          CTRL_BUF_B    = 2;
  localparam int          CTRL_CKS_HI   = 1;
  localparam int          CTRL_CKS_LO   = 0;
  // Output compare control fields
  localparam int          OC_SEL        = 4;
  localparam int          OC_OE_A       = 3;
  localparam int          OC_OE_B       = 2;
  localparam int          OC_LVL_A      = 1;
  localparam int          OC_LVL_B      = 0;
  // Flag register fields (interrupt enable register uses the same bits)
  localparam int          FL_CAP_A      = 7;
  localparam int          FL_MATCH_A    = 3;
  localparam int          FL_MATCH_B    = 2;
  localparam int          FL_WRAP       = 1;
  localparam int          FL_CLR_A      = 0;
  // Clock select codes
  localparam logic [1:0]  CKS_DIV2      = 2'h0;
  localparam logic [1:0]  CKS_DIV8      = 2'h1;
  localparam logic [1:0]  CKS_DIV32     = 2'h2;
  localparam logic [1:0]  CKS_EXT       = 2'h3;
  localparam logic [4:0]  DIV2_MASK     = 5'h01;
  localparam logic [4:0]  DIV8_MASK     = 5'h07;
  localparam logic [4:0]  DIV32_MASK    = 5'h1F;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              wr;
    logic              rd;
    logic [DATA_W-1:0] wdata;
  } frcct_bus_req_t;
endpackage

// >>> frcct_timer.sv
// Free-running 16-bit counter with two compare and four capture channels
module frcct_timer
  import frcct_pkg::*;
(
  input  wire logic                      core_clk,
  input  wire logic                      reset,
  input  wire logic                      low_power_entry,
  input  wire frcct_pkg::frcct_bus_req_t bus_req,
  output logic [frcct_pkg::DATA_W-1:0]   bus_rdata_r,
  input  wire logic [3:0]                capture_pin,
  input  wire logic                      ext_count_clock,
  output logic                           compare_pin_a_r,
  output logic                           compare_pin_b_r,
  output logic                           compare_a_output_enable,
  output logic                           compare_b_output_enable,
  output logic                           timer_irq_r
);
  import frcct_pkg::*;

  logic [7:0]       ctrl_r;
  logic [7:0]       out_ctrl_r;
  logic [7:0]       flags_r;
  logic [7:0]       seen_r;
  logic [7:0]       irq_en_r;
  logic [7:0]       temp_r;
  logic [CNT_W-1:0] frc_r;
  logic [CNT_W-1:0] cmp_a_r;
  logic [CNT_W-1:0] cmp_b_r;
  logic [CNT_W-1:0] cap_r [NUM_CAP];
  logic [PRESC_W-1:0] presc_r;
  logic [4:0]       sync1_r;
  logic [4:0]       sync2_r;
  logic [4:0]       prev_r;

  // Pin synchronisers and edge detection, channel 4 is the external clock
  logic [4:0] pins_in;
  logic [4:0] rise;
  logic [4:0] fall;
  logic [3:0] cap_edge;
  assign pins_in = {ext_count_clock, capture_pin};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
          prev_r[gi]  <= 1'b0;
        end else begin
          sync1_r[gi] <= pins_in[gi];
          sync2_r[gi] <= sync1_r[gi];
          prev_r[gi]  <= sync2_r[gi];
        end
      end
      assign rise[gi] = sync2_r[gi] & ~prev_r[gi];
      assign fall[gi] = ~sync2_r[gi] & prev_r[gi];
    end
    for (gi = 0; gi < NUM_CAP; gi++) begin : g_edge
      assign cap_edge[gi] = ctrl_r[CTRL_EDGE_A-gi] ? rise[gi] : fall[gi];
    end
  endgenerate

  // Bus decode
  wire       wr       = bus_req.wr;
  wire       rd       = bus_req.rd;
  wire [3:0] addr     = bus_req.addr;
  wire [7:0] wdata    = bus_req.wdata;
  wire       cmp_sel  = out_ctrl_r[OC_SEL];
  wire       wr_frc_l = wr && addr == ADDR_FRC_LO;
  wire       wr_cmp_l = wr && addr == ADDR_CMP_LO;
  wire       wr_hi    = wr && (addr == ADDR_FRC_HI || addr == ADDR_CMP_HI);
  wire       wr_flags = wr && addr == ADDR_FLAGS;
  wire       rd_flags = rd && addr == ADDR_FLAGS;
  wire       cap_addr = addr[3];
  wire [1:0] cap_idx  = addr[2:1];
  wire       rd_hi16  = rd && !addr[0] && (cap_addr || addr == ADDR_FRC_HI);
  wire       buf_a    = ctrl_r[CTRL_BUF_A];
  wire       buf_b    = ctrl_r[CTRL_BUF_B];
  wire       wr_ctrl  = wr && addr == ADDR_CTRL;
  wire       wr_oc    = wr && addr == ADDR_OUT_CTRL;
  wire       wr_irq_en = wr && addr == ADDR_IRQ_EN;
  wire       wr_cmp_a = wr_cmp_l && !cmp_sel;
  wire       wr_cmp_b = wr_cmp_l && cmp_sel;
  wire [CNT_W-1:0] wr_word = {temp_r, wdata};

  // Count clock selection
  wire [1:0] cks = {ctrl_r[CTRL_CKS_HI], ctrl_r[CTRL_CKS_LO]};
  logic tick;
  always_comb begin
    unique case (cks)
      CKS_DIV2:  tick = (presc_r & DIV2_MASK) == DIV2_MASK;
      CKS_DIV8:  tick = (presc_r & DIV8_MASK) == DIV8_MASK;
      CKS_DIV32: tick = (presc_r & DIV32_MASK) == DIV32_MASK;
      CKS_EXT:   tick = rise[4];
    endcase
  end

  // Match fires on the count clock that moves the counter off the value
  wire match_a = tick && frc_r == cmp_a_r && !(wr_cmp_l && !cmp_sel);
  wire match_b = tick && frc_r == cmp_b_r && !(wr_cmp_l && cmp_sel);
  wire clr_a   = match_a && flags_r[FL_CLR_A];
  wire wrap    = tick && frc_r == CNT_MAX && !clr_a && !wr_frc_l;

  logic [CNT_W-1:0] frc_nxt;
  always_comb begin
    if (clr_a)
      frc_nxt = CNT_RST;
    else if (wr_frc_l)
      frc_nxt = {temp_r, wdata};
    else if (tick)
      frc_nxt = frc_r + 16'h0001;
    else
      frc_nxt = frc_r;
  end

  // Flag set and clear, set wins over a simultaneous clear
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  logic [7:0] flags_nxt;
  assign flag_set = {cap_edge[0], cap_edge[1], cap_edge[2], cap_edge[3],
                     match_a, match_b, wrap, 1'b0};
  assign flag_clr = (wr_flags ? (~wdata & seen_r) : 8'h00) & 8'hFE;
  always_comb begin
    flags_nxt = (flags_r & ~flag_clr) | flag_set;
    if (wr_flags)
      flags_nxt[FL_CLR_A] = wdata[FL_CLR_A];
  end

  // Read mux
  logic [7:0] rd_mux;
  wire [CNT_W-1:0] cmp_cur = cmp_sel ? cmp_b_r : cmp_a_r;
  always_comb begin
    if (cap_addr)
      rd_mux = addr[0] ? temp_r : cap_r[cap_idx][15:8];
    else begin
      unique case (addr[2:0])
        3'h0:    rd_mux = irq_en_r;
        3'h1:    rd_mux = flags_r;
        3'h2:    rd_mux = frc_r[15:8];
        3'h3:    rd_mux = temp_r;
        3'h4:    rd_mux = cmp_cur[15:8];
        3'h5:    rd_mux = cmp_cur[7:0];
        3'h6:    rd_mux = ctrl_r;
        default: rd_mux = out_ctrl_r;
      endcase
    end
  end
  wire [7:0] lo_for_temp = cap_addr ? cap_r[cap_idx][7:0] : frc_r[7:0];

  // Software-written configuration registers
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ctrl_r     <= CTRL_RST;
      out_ctrl_r <= OUT_CTRL_RST;
      irq_en_r   <= IRQ_EN_RST;
    end else if (low_power_entry) begin
      ctrl_r     <= CTRL_RST;
      out_ctrl_r <= OUT_CTRL_RST;
      irq_en_r   <= IRQ_EN_RST;
    end else begin
      if (wr_ctrl)
        ctrl_r <= wdata;
      if (wr_oc)
        out_ctrl_r <= wdata | OUT_CTRL_FIX;
      if (wr_irq_en)
        irq_en_r <= wdata;
    end
  end

  // Byte latch and registered read data
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      temp_r      <= 8'h00;
      bus_rdata_r <= 8'h00;
    end else if (low_power_entry) begin
      temp_r      <= 8'h00;
      bus_rdata_r <= 8'h00;
    end else begin
      if (wr_hi)
        temp_r <= wdata;
      else if (rd_hi16)
        temp_r <= lo_for_temp;
      if (rd)
        bus_rdata_r <= rd_mux;
    end
  end

  // Flags, read-as-one tracking and the interrupt request
  wire [7:0] seen_nxt = rd_flags ? (flags_r | (seen_r & flags_nxt)) : (seen_r & flags_nxt);
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      flags_r     <= FLAGS_RST;
      seen_r      <= FLAGS_RST;
      timer_irq_r <= 1'b0;
    end else if (low_power_entry) begin
      flags_r     <= FLAGS_RST;
      seen_r      <= FLAGS_RST;
      timer_irq_r <= 1'b0;
    end else begin
      flags_r     <= flags_nxt;
      seen_r      <= seen_nxt;
      timer_irq_r <= |(flags_nxt[7:1] & irq_en_r[7:1]);
    end
  end

  // Prescaler and free-running counter
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      presc_r <= '0;
      frc_r   <= CNT_RST;
    end else if (low_power_entry) begin
      presc_r <= '0;
      frc_r   <= CNT_RST;
    end else begin
      presc_r <= presc_r + 5'h01;
      frc_r   <= frc_nxt;
    end
  end

  // Compare registers, loaded as a pair through the byte latch
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cmp_a_r <= CNT_MAX;
      cmp_b_r <= CNT_MAX;
    end else if (low_power_entry) begin
      cmp_a_r <= CNT_MAX;
      cmp_b_r <= CNT_MAX;
    end else begin
      if (wr_cmp_a)
        cmp_a_r <= wr_word;
      if (wr_cmp_b)
        cmp_b_r <= wr_word;
    end
  end

  // Compare pins keep their level until the next match
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      compare_pin_a_r <= 1'b0;
      compare_pin_b_r <= 1'b0;
    end else if (low_power_entry) begin
      compare_pin_a_r <= 1'b0;
      compare_pin_b_r <= 1'b0;
    end else begin
      if (match_a)
        compare_pin_a_r <= out_ctrl_r[OC_LVL_A];
      if (match_b)
        compare_pin_b_r <= out_ctrl_r[OC_LVL_B];
    end
  end

  assign compare_a_output_enable = out_ctrl_r[OC_OE_A];
  assign compare_b_output_enable = out_ctrl_r[OC_OE_B];

  // Capture registers; C and D become buffers of A and B when enabled
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NUM_CAP; i++)
        cap_r[i] <= CNT_RST;
    end else if (low_power_entry) begin
      for (int i = 0; i < NUM_CAP; i++)
        cap_r[i] <= CNT_RST;
    end else begin
      if (cap_edge[0])
        cap_r[0] <= frc_r;
      if (cap_edge[1])
        cap_r[1] <= frc_r;
      if (buf_a && cap_edge[0])
        cap_r[2] <= cap_r[0];
      else if (!buf_a && cap_edge[2])
        cap_r[2] <= frc_r;
      if (buf_b && cap_edge[1])
        cap_r[3] <= cap_r[1];
      else if (!buf_b && cap_edge[3])
        cap_r[3] <= frc_r;
    end
  end
endmodule // frcct_timer

// >>> frcct_timer_checker.sv
// Port-level assertions for the capture/compare timer
module frcct_timer_checker
  import frcct_pkg::*;
(
  input wire logic                      core_clk,
  input wire logic                      reset,
  input wire logic                      low_power_entry,
  input wire frcct_pkg::frcct_bus_req_t bus_req,
  input wire logic [frcct_pkg::DATA_W-1:0] bus_rdata_r,
  input wire logic [3:0]                capture_pin,
  input wire logic                      ext_count_clock,
  input wire logic                      compare_pin_a_r,
  input wire logic                      compare_pin_b_r,
  input wire logic                      compare_a_output_enable,
  input wire logic                      compare_b_output_enable,
  input wire logic                      timer_irq_r
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  wire logic wr_oc = bus_req.wr && (bus_req.addr == ADDR_OUT_CTRL) && !low_power_entry;
  wire logic rd_oc = bus_req.rd && (bus_req.addr == ADDR_OUT_CTRL) && !low_power_entry;
  a_oc_fixed_bits: assert property (rd_oc |=> bus_rdata_r[7:5] == 3'h7)
    else $error("out ctrl top bits not all ones");
  a_oc_read_back: assert property (wr_oc ##1 !bus_req.wr ##1 rd_oc
    |=> bus_rdata_r[4:0] == $past(bus_req.wdata[4:0], 3))
    else $error("out ctrl low bits differ from written value");
  a_oe_a_follow: assert property (wr_oc |=> compare_a_output_enable == $past(bus_req.wdata[3]))
    else $error("output enable a does not follow bit 3");
  a_oe_b_follow: assert property (wr_oc |=> compare_b_output_enable == $past(bus_req.wdata[2]))
    else $error("output enable b does not follow bit 2");
  a_lp_oe_clear: assert property (low_power_entry |=> !compare_a_output_enable && !compare_b_output_enable)
    else $error("output enables survive low power entry");
  a_lp_pins_low: assert property (low_power_entry [*2] |=> !compare_pin_a_r && !compare_pin_b_r && !timer_irq_r)
    else $error("pins or irq survive low power entry");
  a_rdata_holds: assert property (!bus_req.rd && !low_power_entry |=> $stable(bus_rdata_r))
    else $error("read data changed without a read");
  a_reset_pins_low: assert property ($fell(reset) |-> !compare_pin_a_r && !compare_pin_b_r && !compare_a_output_enable)
    else $error("compare outputs not low after reset");
  c_oc_write: cover property (wr_oc);
  c_pin_a_rise: cover property ($rose(compare_pin_a_r));
  c_irq_seen: cover property ($rose(timer_irq_r));
endmodule // frcct_timer_checker

bind frcct_timer frcct_timer_checker u_chk (.core_clk(core_clk), .reset(reset),
  .low_power_entry(low_power_entry), .bus_req(bus_req), .bus_rdata_r(bus_rdata_r),
  .capture_pin(capture_pin), .ext_count_clock(ext_count_clock),
  .compare_pin_a_r(compare_pin_a_r), .compare_pin_b_r(compare_pin_b_r),
  .compare_a_output_enable(compare_a_output_enable),
  .compare_b_output_enable(compare_b_output_enable), .timer_irq_r(timer_irq_r));

// >>> frcct_timer_tb.sv
// Self-checking testbench for the capture/compare timer
module frcct_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import frcct_pkg::*;
  logic core_clk = 1'b0, reset = 1'b1, low_power_entry = 1'b0;
  logic [3:0] capture_pin = 4'h0;
  logic ext_count_clock, pin_a, pin_b, oe_a, oe_b, irq;
  frcct_bus_req_t bus_req;
  logic [7:0] bus_rdata_r, b;
  logic [15:0] v;
  int errors = 0, n_compared = 0;
  frcct_timer uut (.core_clk(core_clk), .reset(reset), .low_power_entry(low_power_entry),
    .bus_req(bus_req), .bus_rdata_r(bus_rdata_r), .capture_pin(capture_pin),
    .ext_count_clock(ext_count_clock), .compare_pin_a_r(pin_a), .compare_pin_b_r(pin_b),
    .compare_a_output_enable(oe_a), .compare_b_output_enable(oe_b), .timer_irq_r(irq));
  frcct_cpu_model cpu (.core_clk(core_clk), .bus_rdata_r(bus_rdata_r), .bus_req(bus_req),
    .ext_count_clock(ext_count_clock));
  initial forever #4 core_clk = ~core_clk;
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_in(input string nm, input int lo, input int hi, input logic [15:0] g);
    n_compared++;
    if ($isunknown(g) || !(g >= lo && g <= hi)) begin
      errors++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  task automatic results();
    $display("errors=%0d n_compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wait_sync();
    repeat (6) @(posedge core_clk);
  endtask
  task automatic t_reset_out_ctrl();
    cpu.rd(ADDR_CTRL, b); chk("ctrl reset", 16'(CTRL_RST), 16'(b));
    cpu.rd(ADDR_OUT_CTRL, b); chk("out ctrl reset", 16'h00E0, 16'(b));
    chk("oe reset", 16'h0000, {14'h0, oe_a, oe_b});
    cpu.wr(ADDR_OUT_CTRL, 8'hFF); cpu.rd(ADDR_OUT_CTRL, b);
    chk("oe set", 16'h0003, {14'h0, oe_a, oe_b});
    cpu.wr(ADDR_OUT_CTRL, 8'h00); cpu.rd(ADDR_OUT_CTRL, b); chk("out ctrl fixed", 16'h00E0, 16'(b));
    cpu.wr(ADDR_OUT_CTRL, 8'h1F);
    @(posedge core_clk) low_power_entry <= 1'b1;
    repeat (2) @(posedge core_clk);
    low_power_entry <= 1'b0;
    cpu.rd(ADDR_OUT_CTRL, b); chk("out ctrl low power", 16'h00E0, 16'(b));
  endtask
  task automatic t_counter();
    cpu.wr(ADDR_CTRL, 8'h03);
    cpu.wr16(ADDR_FRC_HI, 16'hAA55); cpu.rd16(ADDR_FRC_HI, v); chk("counter write", 16'hAA55, v);
    cpu.wr16(ADDR_FRC_HI, 16'h00FF); cpu.rd(ADDR_FRC_HI, b);
    cpu.ext_pulse(); cpu.rd(ADDR_FRC_LO, b); chk("latched low byte", 16'h00FF, 16'(b));
    cpu.rd16(ADDR_FRC_HI, v); chk("external count", 16'h0100, v);
    cpu.wr16(ADDR_CMP_HI, 16'h1234); cpu.wr(ADDR_OUT_CTRL, 8'h10);
    cpu.wr16(ADDR_CMP_HI, 16'h5678); cpu.rd16(ADDR_CMP_HI, v); chk("compare b", 16'h5678, v);
    cpu.wr(ADDR_OUT_CTRL, 8'h00); cpu.rd16(ADDR_CMP_HI, v); chk("compare a", 16'h1234, v);
  endtask
  task automatic t_match();
    cpu.wr(ADDR_IRQ_EN, 8'h08); cpu.wr(ADDR_FLAGS, 8'h01); cpu.wr(ADDR_OUT_CTRL, 8'h0A);
    cpu.wr16(ADDR_CMP_HI, 16'h0012); cpu.wr16(ADDR_FRC_HI, 16'h0011);
    cpu.ext_pulse(); chk("pin before leaving match", 16'h0000, 16'(pin_a));
    cpu.ext_pulse(); chk("pin level on match", 16'h0001, 16'(pin_a));
    cpu.rd16(ADDR_FRC_HI, v); chk("clear on match", 16'h0000, v);
    cpu.rd(ADDR_FLAGS, b); chk("match flag", 16'h0009, 16'(b));
    chk("irq on match", 16'h0001, 16'(irq));
    cpu.wr(ADDR_FLAGS, 8'h01); cpu.rd(ADDR_FLAGS, b); chk("flag cleared", 16'h0001, 16'(b));
    chk("irq cleared", 16'h0000, 16'(irq));
    chk("pin b after reset", 16'h0000, 16'(pin_b));
    cpu.wr(ADDR_OUT_CTRL, 8'h15); cpu.wr16(ADDR_CMP_HI, 16'h0001);
    cpu.ext_pulse(); cpu.ext_pulse(); chk("pin b level on match", 16'h0001, 16'(pin_b));
  endtask
  task automatic t_capture();
    cpu.wr(ADDR_FLAGS, 8'h00); cpu.wr(ADDR_CTRL, 8'h83); cpu.wr16(ADDR_FRC_HI, 16'h0100);
    @(posedge core_clk) capture_pin[0] <= 1'b1;
    wait_sync(); cpu.rd16(ADDR_CAP_BASE, v); chk("capture a", 16'h0100, v);
    cpu.wr(ADDR_CTRL, 8'h8B); cpu.wr16(ADDR_FRC_HI, 16'h0200);
    @(posedge core_clk) capture_pin[0] <= 1'b0;
    wait_sync(); cpu.rd16(ADDR_CAP_BASE, v); chk("unselected edge", 16'h0100, v);
    @(posedge core_clk) capture_pin[0] <= 1'b1;
    wait_sync(); cpu.rd16(ADDR_CAP_BASE, v); chk("buffered a", 16'h0200, v);
    cpu.rd16(ADDR_CAP_BASE + 4'h4, v); chk("buffer c", 16'h0100, v);
    @(posedge core_clk) capture_pin[2] <= 1'b1;
    wait_sync();
    capture_pin[2] <= 1'b0;
    wait_sync(); cpu.rd(ADDR_FLAGS, b); chk("flags a and c", 16'h00A0, 16'(b & 8'hF0));
    cpu.rd16(ADDR_CAP_BASE + 4'h4, v); chk("buffer c kept", 16'h0100, v);
    cpu.wr(ADDR_CTRL, 8'h47); cpu.wr16(ADDR_FRC_HI, 16'h0300);
    @(posedge core_clk) capture_pin[1] <= 1'b1;
    wait_sync();
    capture_pin[1] <= 1'b0;
    cpu.wr16(ADDR_FRC_HI, 16'h0400);
    @(posedge core_clk) capture_pin[1] <= 1'b1;
    wait_sync(); cpu.rd16(ADDR_CAP_BASE + 4'h2, v); chk("buffered b", 16'h0400, v);
    cpu.rd16(ADDR_CAP_BASE + 4'h6, v); chk("buffer d", 16'h0300, v);
  endtask
  task automatic t_wrap_prescale();
    cpu.wr16(ADDR_FRC_HI, 16'hFFFF); cpu.ext_pulse();
    cpu.rd(ADDR_FLAGS, b); chk("wrap flag", 16'h0002, 16'(b & 8'h02));
    cpu.rd16(ADDR_FRC_HI, v); chk("wrap value", 16'h0000, v);
    for (int k = 0; k < 3; k++) begin
      cpu.wr(ADDR_CTRL, 8'(k)); cpu.wr16(ADDR_FRC_HI, 16'h0000);
      repeat (64) @(posedge core_clk);
      cpu.rd16(ADDR_FRC_HI, v); chk_in("prescaled count", (64 >> (2 * k + 1)) - 1, (64 >> (2 * k + 1)) + 3, v);
    end
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    t_reset_out_ctrl();
    t_counter();
    t_match();
    t_capture();
    t_wrap_prescale();
    results();
  end
  initial begin
    #100us;
    errors++;
    results();
  end
endmodule // frcct_timer_tb
